/* File: ddrp_core.sv */
// DDR pin command interface, device side: command decode, mode registers,
// bursts on both strobe edges, write masking and power-down on clock gate.
// Assumes all pins are asynchronous to sys_clk_i, which oversamples the link.
// Function
// - Data moves on both clock edges
// - Controls sampled on rising true clock
// - Read strobe edge-aligned; write data centred
// - Device drives strobe on reads only
// - Output timing aligned to input clock
// - Read latency 2 or 2.5 cycles
// - Burst 2/4/8, sequential or interleaved
// - Masked write beats not stored
// - Mask never affects read data
// - Lower/upper mask and strobe cover bytes
// - Clock gate low enters power-down modes
// - Clock gate disables outputs asynchronously
// - Power-down disables all but clock, gate
// - Chip select high masks every command
// - Command from select and three strobes
// - Two bank bits pick one of four
// - Row on activate, column on read/write
// - Column bits A0-A9 plus A11 by-four; core keeps only A[COL-1:0], A0-A2 by default
// - Precharge-all bit high closes all banks
// - Bank bits select base or extended mode
// - Mode load with all strobes low, all banks idle
// - Mode fields length, order, latency, test
`timescale 1ns/1ps
`default_nettype none
`include "ddrp_regs.svh"
module ddrp_core
  import ddrp_pkg::*;
#(
  parameter int AW  = 13,
  parameter int COL = 3
) (
  input  wire logic         sys_clk_i,                // System clock 10 MHz
  input  wire logic         resetn_i,                 // Async reset, active low
  input  wire logic         ce_i,                     // Clock enable
  input  wire logic         diff_clock_pair_i,        // True clock pin
  input  wire logic         clk_gate_i,               // Clock gate pin
  input  wire logic         cs_n_i,                   // Chip select, low active
  input  wire logic         ras_n_i,                  // Row strobe
  input  wire logic         cas_n_i,                  // Column strobe
  input  wire logic         we_n_i,                   // Write strobe
  input  wire logic         bank_select_lo_i,         // Bank bit 0
  input  wire logic         bank_select_hi_i,         // Bank bit 1
  input  wire logic [AW-1:0] addr_i,                  // Address pins
  input  wire logic [15:0]  dq_i,                     // Data pins in
  output logic      [15:0]  dq_o,                     // Data pins out
  output logic              dq_oe_o,                  // Data drive enable
  input  wire logic         lower_data_strobe_i,      // Lower strobe in
  input  wire logic         upper_data_strobe_i,      // Upper strobe in
  output logic              lower_data_strobe_o,      // Lower strobe out
  output logic              upper_data_strobe_o,      // Upper strobe out
  output logic              dqs_oe_o,                 // Strobe drive enable
  input  wire logic         lower_write_mask_i,       // Lower write mask
  input  wire logic         upper_write_mask_i,       // Upper write mask
  output logic      [AW-1:0] mode_reg_o,              // Base mode register
  output logic      [AW-1:0] ext_mode_reg_o,          // Extended mode register
  output logic      [3:0]   bank_open_o,              // Open rows per bank
  output logic              power_down_o,             // In power-down
  output logic              self_refresh_o,           // In self refresh
  output logic              dll_locked_o              // Output timing locked
);
  if (AW < 12 || COL < 1 || COL > 5) begin : g_bad_param
    $error("ddrp_core: bad parameters");
  end

  localparam int MW = COL + 2;

  // Pin synchronisers; the clock gate also bypasses them for output disable
  logic [AW+27:0] raw_w, syn_w;
  assign raw_w = {diff_clock_pair_i, clk_gate_i, cs_n_i, ras_n_i, cas_n_i, we_n_i,
                  bank_select_hi_i, bank_select_lo_i, addr_i, dq_i,
                  lower_data_strobe_i, upper_data_strobe_i,
                  lower_write_mask_i, upper_write_mask_i};
  ddrp_sync #(.W(AW + 28)) u_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .d_i       (raw_w),
    .q_o       (syn_w)
  );

  logic          ck_s, gate_s, csn_s, rasn_s, casn_s, wen_s, lower_data_strobe_s, upper_data_strobe_s, ldm_s, udm_s;
  logic [1:0]    ba_s;
  logic [AW-1:0] a_s;
  logic [15:0]   dq_s;
  assign {ck_s, gate_s, csn_s, rasn_s, casn_s, wen_s, ba_s, a_s, dq_s,
          lower_data_strobe_s, upper_data_strobe_s, ldm_s, udm_s} = syn_w;

  logic ck_q, lower_data_strobe_q, upper_data_strobe_q;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ck_q   <= 1'b0;
      lower_data_strobe_q <= 1'b0;
      upper_data_strobe_q <= 1'b0;
    end else if (ce_i) begin
      ck_q   <= ck_s;
      lower_data_strobe_q <= lower_data_strobe_s;
      upper_data_strobe_q <= upper_data_strobe_s;
    end
  end
  logic ck_rise, ck_edge, lower_data_strobe_edge, upper_data_strobe_edge;
  assign ck_rise   = ck_s & ~ck_q;
  assign ck_edge   = ck_s ^ ck_q;
  assign lower_data_strobe_edge = lower_data_strobe_s ^ lower_data_strobe_q;
  assign upper_data_strobe_edge = upper_data_strobe_s ^ upper_data_strobe_q;

  // Command decode; inputs masked while powered down
  ddrp_state_type st_q;
  logic awake;
  assign awake = (st_q != DDRP_ST_PDN) && (st_q != DDRP_ST_SREF);
  ddrp_cmd_type cmd;
  always_comb begin
    if (!awake || !gate_s || csn_s) begin
      cmd = DDRP_CMD_DESEL;
    end else begin
      cmd = ddrp_cmd_type'({1'b0, rasn_s, casn_s, wen_s});
    end
  end
  logic cmd_v;
  assign cmd_v = ck_rise;

  // Mode registers
  logic [AW-1:0] mr_q, emr_q;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mr_q  <= AW'(`DDRP_MR_RESET);
      emr_q <= AW'(`DDRP_EMR_RESET);
    end else if (ce_i && cmd_v && cmd == DDRP_CMD_MRS && bank_open_o == 4'h0) begin
      if (!ba_s[0]) begin
        mr_q <= a_s;
      end else begin
        emr_q <= a_s;
      end
    end
  end

  logic [3:0] blen;
  always_comb begin
    case (mr_q[`DDRP_MR_BL_MSB:`DDRP_MR_BL_LSB])
      `DDRP_BL_CODE_2: blen = 4'h2;
      `DDRP_BL_CODE_8: blen = 4'h8;
      default:         blen = 4'h4;
    endcase
  end
  logic interleave, cl_half;
  assign interleave = mr_q[`DDRP_MR_BT_BIT];
  assign cl_half    = (mr_q[`DDRP_MR_CL_MSB:`DDRP_MR_CL_LSB] == `DDRP_CL_CODE_25);

  // Locks after reset or a loop reset, counting link clock periods
  logic [7:0] lock_q;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_q <= 8'h0;
    end else if (ce_i) begin
      if (cmd_v && cmd == DDRP_CMD_MRS && !ba_s[0] && a_s[`DDRP_MR_DLLRST_BIT]) begin
        lock_q <= 8'h0;
      end else if (ck_rise && lock_q != 8'(`DDRP_LOCK_CYCLES)) begin
        lock_q <= lock_q + 8'h1;
      end
    end
  end

  // Bank state
  logic [3:0] bsel;
  assign bsel = 4'h1 << ba_s;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bank_open_o <= 4'h0;
    end else if (ce_i && cmd_v) begin
      case (cmd)
        DDRP_CMD_ACT: bank_open_o <= bank_open_o | bsel;
        DDRP_CMD_PRE: begin
          if (a_s[`DDRP_PRE_ALL_BIT]) begin
            bank_open_o <= 4'h0;
          end else begin
            bank_open_o <= bank_open_o & ~bsel;
          end
        end
        default: bank_open_o <= bank_open_o;
      endcase
    end
  end

  // Burst control; beat address = bank, column base and beat offset
  logic [1:0]    bk_q;
  logic [COL-1:0] col_q;
  logic [3:0]    beat_q, lat_q;
  logic          ap_q;
  ddrp_state_type st_d;

  function automatic logic [COL-1:0] beat_col(input logic [COL-1:0] base,
                                              input logic [3:0] n);
    logic [COL-1:0] mask, off;
    mask = COL'(blen - 4'h1);
    off  = COL'(n);
    if (interleave) begin
      beat_col = (base & ~mask) | ((base ^ off) & mask);
    end else begin
      beat_col = (base & ~mask) | ((base + off) & mask);
    end
  endfunction : beat_col

  always_comb begin
    st_d = st_q;
    case (st_q)
      DDRP_ST_IDLE: begin
        if (!gate_s && ck_rise) begin
          st_d = (cmd_v && rasn_s == 1'b0 && casn_s == 1'b0 && !csn_s)
                 ? DDRP_ST_SREF : DDRP_ST_PDN;
        end else if (cmd_v && cmd == DDRP_CMD_RD && bank_open_o[ba_s]) begin
          st_d = DDRP_ST_RD;
        end else if (cmd_v && cmd == DDRP_CMD_WR && bank_open_o[ba_s]) begin
          st_d = DDRP_ST_WR;
        end
      end
      DDRP_ST_RD: begin
        if ((ck_edge && lat_q == 4'h0 && beat_q == blen - 4'h1)
            || (cmd_v && (cmd == DDRP_CMD_BST || cmd == DDRP_CMD_PRE))) begin
          st_d = DDRP_ST_IDLE;
        end
      end
      DDRP_ST_WR: begin
        if (beat_q == blen) begin
          st_d = DDRP_ST_IDLE;
        end
      end
      DDRP_ST_PDN, DDRP_ST_SREF: begin
        if (gate_s && ck_rise) begin
          st_d = DDRP_ST_IDLE;
        end
      end
      default: st_d = DDRP_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= DDRP_ST_IDLE;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bk_q   <= 2'h0;
      col_q  <= '0;
      beat_q <= 4'h0;
      lat_q  <= 4'h0;
      ap_q   <= 1'b0;
    end else if (ce_i) begin
      if (st_q == DDRP_ST_IDLE && st_d != DDRP_ST_IDLE) begin
        bk_q   <= ba_s;
        col_q  <= a_s[COL-1:0];
        ap_q   <= a_s[`DDRP_AP_BIT];
        beat_q <= 4'h0;
        lat_q  <= cl_half ? 4'h5 : 4'h4;
      end else if (st_q == DDRP_ST_RD && ck_edge) begin
        if (lat_q != 4'h0) begin
          lat_q <= lat_q - 4'h1;
        end else begin
          beat_q <= beat_q + 4'h1;
        end
      end else if (st_q == DDRP_ST_WR && (lower_data_strobe_edge || upper_data_strobe_edge)) begin
        beat_q <= beat_q + 4'h1;
      end
    end
  end

  // Auto precharge flag at burst end; it closes no bank
  logic ap_done;
  assign ap_done = ap_q && (st_q == DDRP_ST_RD || st_q == DDRP_ST_WR)
                   && st_d == DDRP_ST_IDLE;

  // Beat memory, one byte per lane per location
  logic rd_drive;
  assign rd_drive = (st_q == DDRP_ST_RD) && lat_q == 4'h0;
  logic [1:0] rd_data_q;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      ddrp_beat_if #(.AW(MW), .DW(8)) bif ();
      ddrp_beat_mem #(.AW(MW), .DW(8)) u_mem (
        .sys_clk_i (sys_clk_i),
        .ce_i      (ce_i),
        .port      (bif.mem)
      );
      logic lane_edge, lane_mask;
      assign lane_edge = (g == 0) ? lower_data_strobe_edge : upper_data_strobe_edge;
      assign lane_mask = (g == 0) ? ldm_s : udm_s;
      assign bif.we    = (st_q == DDRP_ST_WR) && lane_edge && !lane_mask;
      assign bif.waddr = {bk_q, beat_col(col_q, beat_q)};
      assign bif.wdata = dq_s[g*8 +: 8];
      assign bif.raddr = {bk_q, beat_col(col_q, (rd_drive && ck_edge) ? beat_q + 4'h1 : beat_q)};
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          dq_o[g*8 +: 8] <= 8'h0;
        end else if (ce_i) begin
          dq_o[g*8 +: 8] <= rd_drive ? bif.rdata : 8'h0;
        end
      end
      assign rd_data_q[g] = 1'b0;
    end
  endgenerate

  // Strobe toggles with each beat, edge-aligned with the data
  logic strobe_q;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strobe_q <= 1'b0;
    end else if (ce_i) begin
      if (rd_drive) begin
        // One stage late, matching the registered beat memory read
        strobe_q <= ck_q;
      end else begin
        strobe_q <= 1'b0;
      end
    end
  end
  assign lower_data_strobe_o = strobe_q;
  assign upper_data_strobe_o = strobe_q;

  // Output drivers off asynchronously when the gate pin drops
  always_ff @(posedge sys_clk_i or negedge resetn_i or negedge clk_gate_i) begin
    if (!resetn_i) begin
      dq_oe_o  <= 1'b0;
      dqs_oe_o <= 1'b0;
    end else if (!clk_gate_i) begin
      dq_oe_o  <= 1'b0;
      dqs_oe_o <= 1'b0;
    end else if (ce_i) begin
      dq_oe_o  <= rd_drive && st_d == DDRP_ST_RD;
      dqs_oe_o <= rd_drive && st_d == DDRP_ST_RD;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_reg_o     <= '0;
      ext_mode_reg_o <= '0;
      power_down_o   <= 1'b0;
      self_refresh_o <= 1'b0;
      dll_locked_o   <= 1'b0;
    end else if (ce_i) begin
      mode_reg_o     <= mr_q;
      ext_mode_reg_o <= emr_q;
      power_down_o   <= (st_q == DDRP_ST_PDN);
      self_refresh_o <= (st_q == DDRP_ST_SREF);
      dll_locked_o   <= (lock_q == 8'(`DDRP_LOCK_CYCLES))
                        && !emr_q[`DDRP_EMR_DLLDIS_BIT];
    end
  end

  logic unused_w;
  assign unused_w = ap_done ^ (|rd_data_q);
endmodule : ddrp_core
`default_nettype wire

/* File: ddrp_regs.svh */
// Constants for the DDR pin command interface: mode fields, codes, timing.
// Assumes inclusion by bare name from the modules.
`ifndef DDRP_REGS_SVH
`define DDRP_REGS_SVH

`define DDRP_MR_BL_LSB        0
`define DDRP_MR_BL_MSB        2
`define DDRP_MR_BT_BIT        3
`define DDRP_MR_CL_LSB        4
`define DDRP_MR_CL_MSB        6
`define DDRP_MR_TM_BIT        7
`define DDRP_MR_DLLRST_BIT    8
`define DDRP_EMR_DLLDIS_BIT   0
`define DDRP_PRE_ALL_BIT      10
`define DDRP_AP_BIT           10
`define DDRP_BL_CODE_2        3'h1
`define DDRP_BL_CODE_4        3'h2
`define DDRP_BL_CODE_8        3'h3
`define DDRP_CL_CODE_2        3'h2
`define DDRP_CL_CODE_25       3'h6
`define DDRP_MR_RESET         13'h0022
`define DDRP_EMR_RESET        13'h0000
`define DDRP_MRD_CYCLES       2
`define DDRP_LOCK_CYCLES      200

`endif

/* File: ddrp_pkg.sv */
// Types shared by the DDR pin command interface modules.
// Assumes ddrp_regs.svh holds the numeric constants.
package ddrp_pkg;

  typedef enum logic [3:0] {
    DDRP_CMD_DESEL = 4'h8,
    DDRP_CMD_NOP   = 4'h7,
    DDRP_CMD_ACT   = 4'h3,
    DDRP_CMD_RD    = 4'h5,
    DDRP_CMD_WR    = 4'h4,
    DDRP_CMD_BST   = 4'h6,
    DDRP_CMD_PRE   = 4'h2,
    DDRP_CMD_REF   = 4'h1,
    DDRP_CMD_MRS   = 4'h0
  } ddrp_cmd_type;

  typedef enum logic [2:0] {
    DDRP_ST_IDLE = 3'b000,
    DDRP_ST_RD   = 3'b001,
    DDRP_ST_WR   = 3'b011,
    DDRP_ST_PDN  = 3'b010,
    DDRP_ST_SREF = 3'b110
  } ddrp_state_type;

endpackage : ddrp_pkg

/* File: ddrp_beat_if.sv */
// Carrier between the core and its beat memory.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface ddrp_beat_if #(parameter int AW = 6, parameter int DW = 8);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport core (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ddrp_beat_if
`default_nettype wire

/* File: ddrp_beat_mem.sv */
// Small byte array holding the beats of the open rows, registered read.
// Assumes the clock enable freezes it along with the core.
`timescale 1ns/1ps
`default_nettype none
module ddrp_beat_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input  wire logic sys_clk_i,  // System clock
  input  wire logic ce_i,       // Clock enable
  ddrp_beat_if.mem  port        // Access port
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge sys_clk_i) begin
    if (ce_i && port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (ce_i) begin
      port.rdata <= mem_q[port.raddr];
    end
  end
endmodule : ddrp_beat_mem
`default_nettype wire

/* File: ddrp_sync.sv */
// Two-flop synchroniser for a bundle of pin levels.
// Assumes inputs are asynchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module ddrp_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,  // System clock
  input  wire logic         resetn_i,   // Async reset, active low
  input  wire logic [W-1:0] d_i,        // Raw pins
  output logic      [W-1:0] q_o         // Synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : ddrp_sync
`default_nettype wire

/* File: ddrp_core_props.sv */
// Concurrent checks on the pins of the DDR pin command interface.
// Assumes it is bound to ddrp_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "ddrp_regs.svh"
module ddrp_core_props #(
  parameter int AW = 13
) (
  input  wire logic          sys_clk_i,            // System clock
  input  wire logic          resetn_i,             // Async reset, active low
  input  wire logic          clk_gate_i,           // Clock gate pin
  input  wire logic [15:0]   dq_o,                 // Read data
  input  wire logic          dq_oe_o,              // Data drive enable
  input  wire logic          lower_data_strobe_o,  // Lower strobe out
  input  wire logic          upper_data_strobe_o,  // Upper strobe out
  input  wire logic          dqs_oe_o,             // Strobe drive enable
  input  wire logic [AW-1:0] mode_reg_o,           // Base mode register
  input  wire logic [3:0]    bank_open_o,          // Open rows
  input  wire logic          power_down_o,         // In power-down
  input  wire logic          self_refresh_o        // In self refresh
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence burst_start;
    $rose(dq_oe_o);
  endsequence
  sequence beat_step;
    dq_oe_o && $past(dq_oe_o) && $changed(dq_o);
  endsequence
  chk_gate_off: assert property (!clk_gate_i |-> !dq_oe_o && !dqs_oe_o)
    else $error("drive enable high while clock gate low");
  chk_oe_pair: assert property (dq_oe_o |-> dqs_oe_o)
    else $error("data driven without strobe");
  chk_burst_hold: assert property (burst_start |-> dq_oe_o [*7])
    else $error("read burst shorter than two beats");
  chk_edge_align: assert property (beat_step |-> $changed(lower_data_strobe_o))
    else $error("read beat changed off a strobe edge");
  chk_lane_strobe: assert property (dqs_oe_o |-> lower_data_strobe_o == upper_data_strobe_o)
    else $error("byte lane strobes differ");
  chk_mode_idle: assert property ($changed(mode_reg_o) |-> bank_open_o == 4'h0)
    else $error("mode register changed with a row open");
  chk_pd_quiet: assert property (power_down_o || self_refresh_o |-> !dq_oe_o && !dqs_oe_o)
    else $error("outputs driven in power-down");
  chk_pd_entry: assert property ($rose(power_down_o) || $rose(self_refresh_o) |-> !clk_gate_i)
    else $error("power-down entered with clock gate high");
  chk_reset_mode: assert property ($rose(resetn_i) |-> ##[0:2] mode_reg_o == `DDRP_MR_RESET)
    else $error("mode register reset value wrong");
endmodule : ddrp_core_props
bind ddrp_core ddrp_core_props #(.AW(AW)) i_props (.sys_clk_i, .resetn_i, .clk_gate_i, .dq_o,
  .dq_oe_o, .lower_data_strobe_o, .upper_data_strobe_o, .dqs_oe_o, .mode_reg_o, .bank_open_o,
  .power_down_o, .self_refresh_o);
`default_nettype wire

/* File: ddrp_ctl_model.sv */
// Memory controller model facing the DDR pin command interface.
// Assumes the bench resolves the shared data and strobe wires.
`timescale 1ns/1ps
`default_nettype none
module ddrp_ctl_model
  import ddrp_pkg::*;
(
  input  wire logic   sys_clk_i,   // System clock
  output logic        link_clk_o,  // Link clock pin
  output logic        gate_o,      // Clock gate pin
  output logic [3:0]  cmd_o,       // Select, row, column, write strobes
  output logic [1:0]  bank_o,      // Bank bits
  output logic [12:0] addr_o,      // Address pins
  output logic [15:0] dq_o,        // Write data
  output logic        dq_oe_o,     // Data drive enable
  output logic        dqs_o,       // Write strobe
  output logic        dqs_oe_o,    // Strobe drive enable
  output logic [1:0]  mask_o       // Upper and lower write mask
);
  initial begin
    link_clk_o = 1'b0;
    gate_o = 1'b1;
    cmd_o = DDRP_CMD_DESEL;
    bank_o = 2'h0;
    addr_o = 13'h0000;
    dq_o = 16'h0000;
    dq_oe_o = 1'b0;
    dqs_o = 1'b0;
    dqs_oe_o = 1'b0;
    mask_o = 2'h0;
    #37;
    forever #400 link_clk_o = ~link_clk_o;
  end
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    @(negedge link_clk_o);
    @(posedge sys_clk_i);
    cmd_o <= c;
    bank_o <= b;
    addr_o <= a;
    @(posedge link_clk_o);
    repeat (4) @(posedge sys_clk_i);
    cmd_o <= DDRP_CMD_NOP;
    bank_o <= ~b;
    addr_o <= ~a;
  endtask : cmd
  task automatic pins(input logic g, input logic [1:0] m);
    @(posedge sys_clk_i);
    gate_o <= g;
    mask_o <= m;
  endtask : pins
  // Beats centred on strobe edges, one per link half period
  task automatic wr(input logic [63:0] d, input logic [7:0] m);
    repeat (2) @(posedge sys_clk_i);
    dqs_oe_o <= 1'b1;
    // Keep the released level so taking the strobe makes no edge
    dqs_o <= ~dqs_o;
    for (int k = 0; k < 4; k++) begin
      dq_o <= d[16*k +: 16];
      dq_oe_o <= 1'b1;
      mask_o <= m[2*k +: 2];
      repeat (2) @(posedge sys_clk_i);
      dqs_o <= ~dqs_o;
      repeat (2) @(posedge sys_clk_i);
    end
    dqs_oe_o <= 1'b0;
    dq_oe_o <= 1'b0;
  endtask : wr
endmodule : ddrp_ctl_model
`default_nettype wire

/* File: tb_ddr_dram_pin_command_interface.sv */
// Self-checking bench for ddrp_core with a controller model on the pins.
// Assumes a 10 MHz system clock and an 800 ns link clock.
`timescale 1ns/1ps
`default_nettype none
`include "ddrp_regs.svh"
module tb_ddr_dram_pin_command_interface
  import ddrp_pkg::*;
;
  logic sys_clk_i, resetn_i, lk, gt, cdq_oe, cdqs, cdqs_oe, dq_oe, lso, uso, dqs_oe, pd, sr, dll;
  logic [3:0] cm, bank_open;
  logic [1:0] bk, cmask;
  logic [12:0] ad, mode_reg, ext_reg;
  logic [15:0] cdq, dq_out;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc_cnt = 0;
  int t2;
  wire [15:0] dq_w = dq_oe ? dq_out : (cdq_oe ? cdq : ~cdq);
  wire lw = dqs_oe ? lso : (cdqs_oe ? cdqs : ~cdqs);
  wire uw = dqs_oe ? uso : (cdqs_oe ? cdqs : ~cdqs);
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  ddrp_ctl_model c (.sys_clk_i(sys_clk_i), .link_clk_o(lk), .gate_o(gt), .cmd_o(cm), .bank_o(bk),
    .addr_o(ad), .dq_o(cdq), .dq_oe_o(cdq_oe), .dqs_o(cdqs), .dqs_oe_o(cdqs_oe), .mask_o(cmask));
  ddrp_core i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .diff_clock_pair_i(lk),
    .clk_gate_i(gt), .cs_n_i(cm[3]), .ras_n_i(cm[2]), .cas_n_i(cm[1]), .we_n_i(cm[0]),
    .bank_select_lo_i(bk[0]), .bank_select_hi_i(bk[1]), .addr_i(ad), .dq_i(dq_w), .dq_o(dq_out),
    .dq_oe_o(dq_oe), .lower_data_strobe_i(lw), .upper_data_strobe_i(uw),
    .lower_data_strobe_o(lso), .upper_data_strobe_o(uso), .dqs_oe_o(dqs_oe),
    .lower_write_mask_i(cmask[0]), .upper_write_mask_i(cmask[1]), .mode_reg_o(mode_reg),
    .ext_mode_reg_o(ext_reg), .bank_open_o(bank_open), .power_down_o(pd), .self_refresh_o(sr),
    .dll_locked_o(dll));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc
  task automatic go(input logic [3:0] cc, input logic [1:0] b, input logic [12:0] a);
    c.cmd(cc, b, a);
    repeat (12) @(posedge lk);
    cyc(4);
  endtask : go
  task automatic rd_beats(output logic [63:0] got, output int lat);
    logic prev;
    int n;
    lat = 0;
    while (dqs_oe !== 1'b1 && lat < 80) begin
      cyc(1);
      lat++;
    end
    for (int k = 0; k < 4; k++) begin
      n = 0;
      while (k > 0 && lso === prev && n < 10) begin
        cyc(1);
        n++;
      end
      prev = lso;
      cyc(2);
      got[16*k +: 16] = dq_out;
    end
  endtask : rd_beats
  task automatic t_mode;
    int n = 0;
    chk("mode reset", `DDRP_MR_RESET, {3'h0, mode_reg});
    chk("drive idle", 16'h0, {14'h0, dqs_oe, dq_oe});
    go(DDRP_CMD_MRS, 2'h1, 13'h0002);
    chk("ext mode", 16'h0002, {3'h0, ext_reg});
    chk("base kept", 16'h0022, {3'h0, mode_reg});
    go(DDRP_CMD_MRS, 2'h1, 13'h0000);
    go(DDRP_CMD_MRS, 2'h0, 13'h012a);
    go(DDRP_CMD_MRS, 2'h0, 13'h002a);
    chk("base mode", 16'h002a, {3'h0, mode_reg});
    while (dll !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk("loop lock", 16'h1, {15'h0, dll});
    $display("t_mode done");
  endtask : t_mode
  task automatic t_banks;
    go(4'hb, 2'h2, 13'h0000);
    chk("deselected act", 16'h0, {12'h0, bank_open});
    go(DDRP_CMD_ACT, 2'h2, 13'h0011);
    go(DDRP_CMD_ACT, 2'h1, 13'h0012);
    chk("banks open", 16'h0006, {12'h0, bank_open});
    go(DDRP_CMD_MRS, 2'h0, 13'h0032);
    chk("mode refused", 16'h002a, {3'h0, mode_reg});
    go(DDRP_CMD_PRE, 2'h2, 13'h0000);
    chk("one closed", 16'h0002, {12'h0, bank_open});
    go(DDRP_CMD_PRE, 2'h0, 13'h0400);
    chk("all closed", 16'h0, {12'h0, bank_open});
    $display("t_banks done");
  endtask : t_banks
  task automatic t_data;
    logic [63:0] got;
    logic [63:0] exp = 64'hffee_55cc_bb44_9988;
    int t25;
    go(DDRP_CMD_ACT, 2'h3, 13'h0005);
    c.cmd(DDRP_CMD_WR, 2'h3, 13'h0000);
    c.wr(64'h7788_5566_3344_1122, 8'h00);
    cyc(16);
    c.cmd(DDRP_CMD_WR, 2'h3, 13'h0000);
    c.wr(64'hffee_ddcc_bbaa_9988, 8'h24);
    c.pins(1'b1, 2'h3);
    cyc(16);
    c.cmd(DDRP_CMD_RD, 2'h3, 13'h0000);
    rd_beats(got, t2);
    for (int k = 0; k < 4; k++) chk("read beat", exp[16*k +: 16], got[16*k +: 16]);
    cyc(12);
    chk("released", 16'h0, {14'h0, dqs_oe, dq_oe});
    go(DDRP_CMD_PRE, 2'h0, 13'h0400);
    go(DDRP_CMD_MRS, 2'h0, 13'h006a);
    go(DDRP_CMD_ACT, 2'h3, 13'h0005);
    c.cmd(DDRP_CMD_RD, 2'h3, 13'h0000);
    rd_beats(got, t25);
    chk("latency step", 16'h4, 16'(t25 - t2));
    chk("late beat", 16'h9988, got[15:0]);
    $display("t_data done");
  endtask : t_data
  task automatic t_power;
    c.pins(1'b0, 2'h0);
    cyc(24);
    chk("power down", 16'h1, {15'h0, pd});
    c.cmd(DDRP_CMD_ACT, 2'h0, 13'h0001);
    c.pins(1'b1, 2'h0);
    cyc(24);
    chk("gated act", 16'h0008, {12'h0, bank_open});
    chk("woken", 16'h0, {15'h0, pd});
    go(DDRP_CMD_PRE, 2'h0, 13'h0400);
    fork
      c.cmd(DDRP_CMD_REF, 2'h0, 13'h0000);
      begin
        @(negedge lk);
        c.pins(1'b0, 2'h0);
      end
    join
    cyc(16);
    chk("self refresh", 16'h1, {15'h0, sr});
    c.pins(1'b1, 2'h0);
    cyc(24);
    chk("refresh exit", 16'h0, {15'h0, sr});
    $display("t_power done");
  endtask : t_power
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    forever begin
      @(posedge sys_clk_i);
      cyc_cnt++;
      if (cyc_cnt == 40000) begin
        error_cnt++;
        test_done;
      end
    end
  end
  initial begin
    resetn_i = 1'b0;
    cyc(12);
    resetn_i <= 1'b1;
    cyc(3);
    t_mode;
    t_banks;
    t_data;
    t_power;
    test_done;
  end
endmodule : tb_ddr_dram_pin_command_interface
`default_nettype wire
